//--- rtl/icsc_pkg.sv
package icsc_pkg;
	// byte offsets on the register bus
	localparam logic [11:0] OFS_FLAG       = 12'h000;
	localparam logic [11:0] OFS_ENABLE     = 12'h040;
	localparam logic [11:0] OFS_PRIO       = 12'h080;
	localparam logic [11:0] OFS_VEC_LATCH  = 12'h100;
	localparam logic [11:0] OFS_ALU_STATUS = 12'h104;
	localparam logic [11:0] OFS_CORE_CTRL  = 12'h108;
	localparam logic [11:0] OFS_CTRL_ONE   = 12'h10c;
	localparam logic [11:0] OFS_CTRL_TWO   = 12'h110;
	localparam logic [11:0] OFS_EVT_STATUS = 12'h114;
	localparam logic [11:0] OFS_EVT_MASK   = 12'h118;
	// field positions
	localparam int IPL_LSB    = 5;
	localparam int TOP_BIT    = 3;
	localparam int NEST_BIT   = 15;
	localparam int TRAP_LSB   = 1;
	localparam int ALT_BIT    = 15;
	localparam int DISABLE_INSTR_ACTIVE_BIT   = 14;
	localparam int LEVEL_LSB  = 8;
	localparam int PRIO_FIELD = 4;
	// vector numbers of the three external inputs
	localparam int EXT_VEC0 = 0;
	localparam int EXT_VEC1 = 20;
	localparam int EXT_VEC2 = 29;
	localparam int SRC_MAX  = 128;
	localparam logic [15:0] RST_WORD = 16'h0000;
	typedef logic [2:0] icsc_prio_t;
	typedef logic [6:0] icsc_vec_t;
	typedef logic [3:0] icsc_level_t;
endpackage

//--- rtl/icsc_arb_if.sv
`timescale 1ns/1ps
interface icsc_arb_if #(parameter int NUM_SRC = 32);
	import icsc_pkg::*;
	logic [NUM_SRC-1:0] flags;
	logic [NUM_SRC-1:0] enables;
	icsc_prio_t         prio [NUM_SRC];
	logic               valid;
	icsc_vec_t          win_vec;
	icsc_prio_t         win_prio;
	modport arb (input flags, enables, prio, output valid, win_vec, win_prio);
	modport ctrl (output flags, enables, prio, input valid, win_vec, win_prio);
endinterface

//--- rtl/icsc_arbiter.sv
`timescale 1ns/1ps
module icsc_arbiter #(
	parameter int NUM_SRC = 32
) (
	icsc_arb_if.arb a
);
	import icsc_pkg::*;
	// scan from the top so an equal level at a lower vector overwrites
	always_comb begin
		a.valid    = 1'b0;
		a.win_vec  = '0;
		a.win_prio = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (a.flags[i] && a.enables[i] && (!a.valid || a.prio[i] >= a.win_prio)) begin
				a.valid    = 1'b1;
				a.win_vec  = 7'(i);
				a.win_prio = a.prio[i];
			end
		end
	end
endmodule

//--- rtl/icsc_edge_detect.sv
`timescale 1ns/1ps
module icsc_edge_detect #(
	parameter int WIDTH = 3
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             reset,
	// pins and polarity
	input  wire logic [WIDTH-1:0] pin,
	input  wire logic [WIDTH-1:0] falling,
	// one-cycle edge pulses
	output logic      [WIDTH-1:0] pulse
);
	logic [WIDTH-1:0] prev_reg;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			prev_reg <= '0;
		end else begin
			prev_reg <= pin;
		end
	end

	assign pulse = (falling & prev_reg & ~pin) | (~falling & ~prev_reg & pin);
endmodule

//--- rtl/icsc_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - every source has a sticky request flag set by hardware, cleared by software
// - every source has its own enable bit
// - every source has a three-bit priority field, eight levels
// - a pending interrupt latches its vector and its priority as new level
// - flag, enable and priority positions follow vector order, source 0 first
// - cpu level low bits sit at 7:5 of the status word, writable
// - core control bit 3 is the level top bit; software may only clear it
// - level code 111 is level 7 or 15 and blocks every user interrupt
// - nesting disable freezes software writes to the level low bits
// - control one bit 15 is nesting disable, zero after reset
// - control one bits 4:1 are hardware-set trap flags
// - control two bit 15 selects the alternate vector table
// - control two bit 14 shows the interrupt-disable instruction, read-only
// - control two bits 2:0 pick falling or rising edge of external inputs
// - unimplemented bits ignore writes and read zero
// - equal levels resolve to the lowest vector number
module icsc_ctrl #(
	parameter int NUM_SRC = 32
) (
	// clock and reset
	input  wire logic               clock,
	input  wire logic               reset,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// request sources
	input  wire logic [NUM_SRC-1:0] periph_req,
	input  wire logic [2:0]         ext_pin,
	// cpu core side
	input  wire logic [3:0]         trap_event,
	input  wire logic               trap_level_set,
	input  wire logic               disable_instr_active_active,
	input  wire logic               cpu_ack,
	output logic                    irq_req,
	output icsc_pkg::icsc_vec_t     irq_vector,
	output icsc_pkg::icsc_level_t   irq_level,
	output icsc_pkg::icsc_level_t   cpu_level,
	output logic                    alt_table_select,
	// event interrupt
	output logic                    irq
);
	import icsc_pkg::*;

	icsc_arb_if #(.NUM_SRC(NUM_SRC)) arb_bus ();

	logic [NUM_SRC-1:0] flag_reg;
	logic [NUM_SRC-1:0] flag_next;
	logic [NUM_SRC-1:0] en_reg;
	logic [NUM_SRC-1:0] en_next;
	icsc_prio_t         prio_reg [NUM_SRC];
	icsc_prio_t         prio_next [NUM_SRC];
	logic [NUM_SRC-1:0] set_vec;
	icsc_vec_t          vec_latch_reg;
	icsc_level_t        level_latch_reg;
	logic               irq_req_reg;
	logic [2:0]         cpu_low_reg;
	logic [2:0]         cpu_low_next;
	logic               cpu_top_reg;
	logic               cpu_top_next;
	logic               nest_reg;
	logic [3:0]         trap_reg;
	logic [3:0]         trap_next;
	logic               alt_reg;
	logic               disable_instr_active_reg;
	logic [2:0]         pol_reg;
	logic [1:0]         evs_reg;
	logic [1:0]         evs_next;
	logic [1:0]         evm_reg;
	logic               irq_reg;
	logic [31:0]        prdata_reg;
	logic               pready_reg;
	logic               pslverr_reg;
	logic [2:0]         ext_pulse;
	logic [15:0]        flag_word [8];
	logic [15:0]        en_word [8];
	logic [15:0]        prio_word [32];

	// bus phases
	wire setup = psel & ~penable;
	wire wr    = psel & penable & pready_reg & pwrite;

	// address decode
	wire in_flag   = paddr[11:5] == OFS_FLAG[11:5];
	wire in_en     = paddr[11:5] == OFS_ENABLE[11:5];
	wire in_prio   = paddr[11:7] == OFS_PRIO[11:7];
	wire in_latch  = paddr == OFS_VEC_LATCH;
	wire in_alu    = paddr == OFS_ALU_STATUS;
	wire in_core   = paddr == OFS_CORE_CTRL;
	wire in_one    = paddr == OFS_CTRL_ONE;
	wire in_two    = paddr == OFS_CTRL_TWO;
	wire in_evs    = paddr == OFS_EVT_STATUS;
	wire in_evm    = paddr == OFS_EVT_MASK;
	wire hit       = in_flag | in_en | in_prio | in_latch | in_alu | in_core | in_one | in_two | in_evs | in_evm;
	wire wr_flag   = wr & in_flag;
	wire wr_en     = wr & in_en;
	wire wr_prio   = wr & in_prio;
	wire wr_alu    = wr & in_alu;
	wire wr_core   = wr & in_core;
	wire wr_one    = wr & in_one;
	wire wr_two    = wr & in_two;
	wire wr_evs    = wr & in_evs;
	wire wr_evm    = wr & in_evm;

	// external inputs feed their own vector slots
	icsc_edge_detect #(.WIDTH(3)) u_edge (
		.clock   (clock),
		.reset   (reset),
		.pin     (ext_pin),
		.falling (pol_reg),
		.pulse   (ext_pulse)
	);

	// per source flag, enable and priority
	for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
		wire fw = wr_flag && paddr[4:2] == 3'(i / 16);
		wire ew = wr_en && paddr[4:2] == 3'(i / 16);
		wire pw = wr_prio && paddr[6:2] == 5'(i / 4);
		assign set_vec[i] = periph_req[i] | (i == EXT_VEC0 && ext_pulse[0])
			| (i == EXT_VEC1 && ext_pulse[1]) | (i == EXT_VEC2 && ext_pulse[2]);
		// set wins over a clearing write in the same cycle
		assign flag_next[i] = set_vec[i] | (fw ? pwdata[i % 16] : flag_reg[i]);
		assign en_next[i]   = ew ? pwdata[i % 16] : en_reg[i];
		assign prio_next[i] = pw ? pwdata[(i % 4) * PRIO_FIELD +: 3] : prio_reg[i];
		assign arb_bus.prio[i] = prio_reg[i];
	end

	assign arb_bus.flags   = flag_reg;
	assign arb_bus.enables = en_reg;

	// read views; sources beyond the count read zero
	for (genvar w = 0; w < 8; w++) begin : g_fw
		for (genvar b = 0; b < 16; b++) begin : g_b
			if (w * 16 + b < NUM_SRC) begin : g_on
				assign flag_word[w][b] = flag_reg[w * 16 + b];
				assign en_word[w][b]   = en_reg[w * 16 + b];
			end else begin : g_off
				assign flag_word[w][b] = 1'b0;
				assign en_word[w][b]   = 1'b0;
			end
		end
	end
	for (genvar p = 0; p < 32; p++) begin : g_pw
		for (genvar f = 0; f < 4; f++) begin : g_f
			if (p * 4 + f < NUM_SRC) begin : g_on
				assign prio_word[p][f * PRIO_FIELD +: PRIO_FIELD] = {1'b0, prio_reg[p * 4 + f]};
			end else begin : g_off
				assign prio_word[p][f * PRIO_FIELD +: PRIO_FIELD] = 4'h0;
			end
		end
	end

	icsc_arbiter #(.NUM_SRC(NUM_SRC)) u_arb (
		.a (arb_bus)
	);

	// request qualification against the current level
	wire [3:0] cur_level = {cpu_top_reg, cpu_low_reg};
	wire       pend      = arb_bus.valid && {1'b0, arb_bus.win_prio} > cur_level;

	// cpu level: ack loads the latched level, software writes only when nesting allowed
	assign cpu_low_next = cpu_ack ? level_latch_reg[2:0]
		: (wr_alu && !nest_reg) ? pwdata[IPL_LSB +: 3] : cpu_low_reg;
	// hardware set wins over a software clear; software can never set
	assign cpu_top_next = trap_level_set | (cpu_ack & level_latch_reg[3])
		| (cpu_top_reg & ~(wr_core & ~pwdata[TOP_BIT]));
	assign trap_next = trap_event | (wr_one ? pwdata[TRAP_LSB +: 4] : trap_reg);
	// event bits: new request raised, trap seen; write one to clear
	wire [1:0] ev_set = {|trap_event, pend & ~irq_req_reg};
	assign evs_next = ev_set | (evs_reg & ~(wr_evs ? pwdata[1:0] : 2'h0));

	wire [15:0] rd_alu  = {8'h00, cpu_low_reg, 5'h00};
	wire [15:0] rd_core = {12'h000, cpu_top_reg, 3'h0};
	wire [15:0] rd_one  = {nest_reg, 10'h000, trap_reg, 1'b0};
	wire [15:0] rd_two  = {alt_reg, disable_instr_active_reg, 11'h000, pol_reg};
	wire [15:0] rd_lat  = {4'h0, level_latch_reg, 1'b0, vec_latch_reg};
	wire [15:0] rd_data = in_flag ? flag_word[paddr[4:2]]
		: in_en ? en_word[paddr[4:2]]
		: in_prio ? prio_word[paddr[6:2]]
		: in_latch ? rd_lat
		: in_alu ? rd_alu
		: in_core ? rd_core
		: in_one ? rd_one
		: in_two ? rd_two
		: in_evs ? {14'h0000, evs_reg}
		: in_evm ? {14'h0000, evm_reg} : RST_WORD;

	// source state
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			flag_reg <= '0;
			en_reg   <= '0;
			prio_reg <= '{default: '0};
		end else begin
			flag_reg <= flag_next;
			en_reg   <= en_next;
			prio_reg <= prio_next;
		end
	end

	// vector latch and request to the core
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			vec_latch_reg   <= '0;
			level_latch_reg <= '0;
			irq_req_reg     <= 1'b0;
		end else begin
			irq_req_reg <= pend;
			if (pend) begin
				vec_latch_reg   <= arb_bus.win_vec;
				level_latch_reg <= {1'b0, arb_bus.win_prio};
			end
		end
	end

	// cpu level and trap flags
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cpu_low_reg <= '0;
			cpu_top_reg <= 1'b0;
			trap_reg    <= '0;
		end else begin
			cpu_low_reg <= cpu_low_next;
			cpu_top_reg <= cpu_top_next;
			trap_reg    <= trap_next;
		end
	end

	// control words
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			nest_reg <= 1'b0;
			alt_reg  <= 1'b0;
			pol_reg  <= '0;
			disable_instr_active_reg <= 1'b0;
		end else begin
			disable_instr_active_reg <= disable_instr_active_active;
			if (wr_one)
				nest_reg <= pwdata[NEST_BIT];
			if (wr_two) begin
				alt_reg <= pwdata[ALT_BIT];
				pol_reg <= pwdata[2:0];
			end
		end
	end

	// event status, mask and interrupt line
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			evs_reg <= '0;
			evm_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			evs_reg <= evs_next;
			irq_reg <= |(evs_next & (wr_evm ? pwdata[1:0] : evm_reg));
			if (wr_evm)
				evm_reg <= pwdata[1:0];
		end
	end

	// apb answer: zero wait states, data captured in the setup cycle
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			prdata_reg  <= '0;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= setup;
			pslverr_reg <= setup & ~hit;
			if (setup)
				prdata_reg <= {16'h0000, rd_data};
		end
	end

	assign prdata           = prdata_reg;
	assign pready           = pready_reg;
	assign pslverr          = pslverr_reg;
	assign irq_req          = irq_req_reg;
	assign irq_vector       = vec_latch_reg;
	assign irq_level        = level_latch_reg;
	assign cpu_level        = {cpu_top_reg, cpu_low_reg};
	assign alt_table_select = alt_reg;
	assign irq              = irq_reg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_flag_sticky: assert property (flag_reg[0] && !wr_flag |=> flag_reg[0])
		else $error("request flag dropped without a write");
	a_flag_sets: assert property (periph_req[1] |=> flag_reg[1])
		else $error("request flag not set by its source");
	a_no_req_below: assert property (!pend |=> !irq_req_reg)
		else $error("request raised at or below cpu level");
	a_latch_level: assert property (pend |=> level_latch_reg == {1'b0, $past(arb_bus.win_prio)}
		&& vec_latch_reg == $past(arb_bus.win_vec))
		else $error("latch does not hold winning vector and level");
	a_lowest_vector: assert property (flag_reg[0] && en_reg[0] && arb_bus.win_prio == prio_reg[0]
		|-> arb_bus.win_vec == 7'h00)
		else $error("tie not resolved to lowest vector");
	a_nest_lock: assert property (nest_reg && wr_alu && !cpu_ack |=> $stable(cpu_low_reg))
		else $error("level bits changed while nesting disabled");
	a_top_clear_only: assert property (!cpu_top_reg && !trap_level_set && !cpu_ack |=> !cpu_top_reg)
		else $error("top level bit set by software");
	a_code7_blocks: assert property (cpu_low_reg == 3'h7 |-> !pend)
		else $error("user request passed at level seven");
	a_trap_flag: assert property (trap_event[2] |=> trap_reg[2] ##1 trap_reg[2] || $past(wr_one))
		else $error("trap flag lost");
	a_edge_flag: assert property (pol_reg[0] && $past(ext_pin[0]) && !ext_pin[0] |=> flag_reg[EXT_VEC0])
		else $error("falling edge did not set external flag");
	a_winner_enabled: assert property (arb_bus.valid |-> |(flag_reg & en_reg))
		else $error("winner without an enabled flag");
	// every raised request must sit above the level it interrupted
	a_level_above: assert property (irq_req_reg |-> level_latch_reg > $past(cur_level))
		else $error("request latched at or below the old cpu level");
	a_ack_loads: assert property (cpu_ack |=> cpu_low_reg == $past(level_latch_reg[2:0]))
		else $error("acknowledge did not load the latched level");

	// nesting disable, table select and polarity writes land on the access edge
	a_nest_write: assert property (wr_one |=> nest_reg == $past(pwdata[NEST_BIT]))
		else $error("nesting disable did not take the written value");
	a_alt_write: assert property (wr_two |=> alt_reg == $past(pwdata[ALT_BIT]))
		else $error("table select did not take the written value");
	a_pol_write: assert property (wr_two |=> pol_reg == $past(pwdata[2:0]))
		else $error("edge polarity did not take the written value");
	// status mirrors the core one cycle late, software cannot touch it
	a_disable_instr_active_status: assert property (1'b1 |=> disable_instr_active_reg == $past(disable_instr_active_active))
		else $error("instruction disable status does not follow the core");

	c_request: cover property (pend ##1 irq_req_reg);
	c_nested: cover property (irq_req_reg && cpu_low_reg != 3'h0);
	c_trap_irq: cover property (|trap_event ##[1:3] irq_reg);
	c_ext_edge: cover property (ext_pulse[0] ##1 flag_reg[EXT_VEC0]);
	c_level_tie: cover property (flag_reg[1] && flag_reg[3] && irq_req_reg && vec_latch_reg == 7'h01);
endmodule

//--- test/icsc_src_model.sv
`timescale 1ns/1ps
module icsc_src_model #(
	parameter int NUM_SRC = 32
) (
	// clock and the core's view of the request
	input  wire logic               clock,
	input  wire logic               irq_req,
	// request sources
	output logic      [NUM_SRC-1:0] periph_req,
	output logic      [2:0]         ext_pin,
	// core side
	output logic      [3:0]         trap_event,
	output logic                    trap_level_set,
	output logic                    disable_instr_active_active,
	output logic                    cpu_ack
);
	logic ack_armed;
	initial begin
		periph_req = '0;
		ext_pin = 3'h0;
		trap_event = 4'h0;
		disable_instr_active_active = 1'b0;
		ack_armed = 1'b0;
	end
	// the core takes a vector only while one is offered; a trap lifts its level
	always @(posedge clock) begin
		cpu_ack <= ack_armed & irq_req & ~cpu_ack;
		trap_level_set <= |trap_event;
	end
	// one-cycle request pulses, several sources at once
	task automatic req(input logic [NUM_SRC-1:0] m);
		@(posedge clock);
		periph_req <= m;
		@(posedge clock);
		periph_req <= '0;
	endtask
	// core may take the vector late
	task automatic ack(input int wait_cyc);
		repeat (wait_cyc) @(posedge clock);
		ack_armed <= 1'b1;
		@(posedge clock);
		ack_armed <= 1'b0;
	endtask
	task automatic pin(input logic [2:0] v);
		@(posedge clock);
		ext_pin <= v;
	endtask
	task automatic trap(input logic [3:0] v);
		@(posedge clock);
		trap_event <= v;
		@(posedge clock);
		trap_event <= 4'h0;
	endtask
	task automatic disable_instr_active(input logic v);
		@(posedge clock);
		disable_instr_active_active <= v;
	endtask
endmodule

//--- test/interrupt_control_status_tb_top.sv
`timescale 1ns/1ps
module interrupt_control_status_tb_top;
	import icsc_pkg::*;
	typedef struct {logic [11:0] a; logic [15:0] d; logic [15:0] e;} icsc_row_t;
	logic        clock   = 1'b0;
	logic        reset   = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata, q;
	logic        pready, pslverr, irq_req, alt_table_select, irq, err_seen;
	logic        cpu_ack, trap_level_set, disable_instr_active_active;
	logic [31:0] periph_req;
	logic [2:0]  ext_pin;
	logic [3:0]  trap_event;
	icsc_vec_t   irq_vector;
	icsc_level_t irq_level, cpu_level;
	int          n_mismatch = 0;
	int          checked    = 0;
	logic [11:0] ra [5] = '{OFS_VEC_LATCH, OFS_ALU_STATUS, OFS_CORE_CTRL, OFS_CTRL_ONE, OFS_CTRL_TWO};
	icsc_row_t   rows [11] = '{
		'{OFS_ALU_STATUS, 16'hffff, 16'h00e0},
		'{OFS_CORE_CTRL,  16'hffff, 16'h0000},
		'{OFS_CTRL_ONE,   16'hffff, 16'h801e},
		'{OFS_ALU_STATUS, 16'h0000, 16'h00e0},
		'{OFS_CTRL_ONE,   16'h0000, 16'h0000},
		'{OFS_ALU_STATUS, 16'h0000, 16'h0000},
		'{OFS_CTRL_TWO,   16'hffff, 16'h8007},
		'{OFS_CTRL_TWO,   16'h0000, 16'h0000},
		'{OFS_ENABLE,     16'h000b, 16'h000b},
		'{OFS_PRIO,       16'hffff, 16'h7777},
		'{OFS_PRIO,       16'h5050, 16'h5050}};

	always #2.5 clock = ~clock;

	icsc_ctrl #(.NUM_SRC(32)) i_dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .periph_req(periph_req), .ext_pin(ext_pin), .trap_event(trap_event),
		.trap_level_set(trap_level_set), .disable_instr_active_active(disable_instr_active_active), .cpu_ack(cpu_ack),
		.irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level), .cpu_level(cpu_level),
		.alt_table_select(alt_table_select), .irq(irq));
	icsc_src_model #(.NUM_SRC(32)) i_src (.clock(clock), .periph_req(periph_req), .ext_pin(ext_pin),
		.trap_event(trap_event), .trap_level_set(trap_level_set), .disable_instr_active_active(disable_instr_active_active),
		.cpu_ack(cpu_ack), .irq_req(irq_req));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// setup, then access held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
		int n = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clock);
			n++;
		end
		if (n == 50) chk(32'h0, 32'h1);
		q = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 16'h0000);
		chk(q, e);
	endtask
	task automatic wait_irq();
		int n = 0;
		while (irq_req !== 1'b1 && n < 20) begin
			@(posedge clock);
			n++;
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		foreach (ra[i]) rd(ra[i], 32'h0);
		chk({31'h0, irq_req}, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, {16'h0000, rows[i].e});
		end
		// unmapped place: refused, reads zero
		wr(12'hffc, 16'hffff);
		rd(12'hffc, 32'h0);
		chk({31'h0, err_seen}, 32'h1);
		// equal priority, two sources in the same cycle
		i_src.req(32'h0000_000a);
		wait_irq();
		chk({25'h0, irq_vector}, 32'd1);
		chk({28'h0, irq_level}, 32'd5);
		rd(OFS_FLAG, 32'h0000_000a);
		rd(OFS_VEC_LATCH, 32'h0000_0501);
		i_src.ack(3);
		repeat (3) @(posedge clock);
		chk({28'h0, cpu_level}, 32'd5);
		chk({31'h0, irq_req}, 32'h0);
		wr(OFS_FLAG, 16'h0000);
		rd(OFS_FLAG, 32'h0);
		// external input 0 on its falling edge only
		wr(OFS_PRIO, 16'h5056);
		wr(OFS_CTRL_TWO, 16'h0001);
		i_src.pin(3'b001);
		repeat (4) @(posedge clock);
		rd(OFS_FLAG, 32'h0);
		i_src.pin(3'b000);
		wait_irq();
		chk({25'h0, irq_vector}, 32'd0);
		chk({28'h0, irq_level}, 32'd6);
		wr(OFS_CTRL_TWO, 16'h8000);
		@(posedge clock);
		chk({31'h0, alt_table_select}, 32'h1);
		// external input 1 now on its rising edge only
		i_src.pin(3'b010);
		rd(OFS_FLAG + 12'h004, 32'h0000_0010);
		wr(OFS_FLAG + 12'h004, 16'h0000);
		i_src.pin(3'b000);
		repeat (2) @(posedge clock);
		rd(OFS_FLAG + 12'h004, 32'h0);
		// a trap lifts the level above seven; software only clears it
		i_src.trap(4'h1);
		repeat (2) @(posedge clock);
		chk({28'h0, cpu_level}, 32'hd);
		rd(OFS_CORE_CTRL, 32'h0000_0008);
		chk({31'h0, irq_req}, 32'h0);
		wr(OFS_CORE_CTRL, 16'h0000);
		rd(OFS_CORE_CTRL, 32'h0);
		// traps raise the event interrupt; old events cleared first
		wr(OFS_EVT_STATUS, 16'h0003);
		wr(OFS_EVT_MASK, 16'h0002);
		@(posedge clock);
		chk({31'h0, irq}, 32'h0);
		i_src.trap(4'hf);
		repeat (3) @(posedge clock);
		chk({31'h0, irq}, 32'h1);
		rd(OFS_CTRL_ONE, 32'h0000_001e);
		wr(OFS_EVT_STATUS, 16'h0002);
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, 32'h0);
		i_src.disable_instr_active(1'b1);
		repeat (3) @(posedge clock);
		rd(OFS_CTRL_TWO, 32'h0000_c000);
		i_src.disable_instr_active(1'b0);
		repeat (3) @(posedge clock);
		rd(OFS_CTRL_TWO, 32'h0000_8000);
		// reset in mid-run clears level, controls and flags again
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		chk({28'h0, cpu_level}, 32'h0);
		rd(OFS_CTRL_ONE, 32'h0);
		rd(OFS_CTRL_TWO, 32'h0);
		rd(OFS_FLAG, 32'h0);
		tally_and_finish();
	end
endmodule
